//--- spfc_pkg.sv
// Constants and types shared by the self-programming flash control block
package spfc_pkg;
    localparam logic [7:0]  SPFC_CSR_INDEX   = 8'h37;
    localparam logic [11:0] SPFC_CSR_ADDR    = 12'h0dc;
    localparam logic [7:0]  SPFC_LOCK_INDEX  = 8'h38;
    localparam logic [11:0] SPFC_LOCK_ADDR   = 12'h0e0;
    localparam logic [7:0]  SPFC_CSR_RESET   = 8'h00;
    localparam logic [5:0]  SPFC_LOCK_RESET  = 6'h3f;
    localparam int          SPFC_BIT_IRQ_EN  = 7;
    localparam int          SPFC_BIT_BUSY    = 6;
    localparam int          SPFC_BIT_REEN    = 4;
    localparam int          SPFC_BIT_LOCKSET = 3;
    localparam int          SPFC_BIT_PAGE_WRITE_CMD   = 2;
    localparam int          SPFC_BIT_PAGE_ERASE_CMD   = 1;
    localparam int          SPFC_BIT_STORE_PROGRAM_ENABLE   = 0;
    localparam logic [4:0]  SPFC_CMD_FILL    = 5'h01;
    localparam logic [4:0]  SPFC_CMD_ERASE   = 5'h03;
    localparam logic [4:0]  SPFC_CMD_WRITE   = 5'h05;
    localparam logic [4:0]  SPFC_CMD_LOCK    = 5'h09;
    localparam logic [4:0]  SPFC_CMD_REEN    = 5'h11;
    localparam logic [2:0]  SPFC_SPM_WINDOW  = 3'h4;
    localparam logic [2:0]  SPFC_LPM_WINDOW  = 3'h3;
    localparam logic [12:0] SPFC_NO_CONCURRENT_READ_SECTION_BOUND  = 13'h1c00;
    localparam logic [12:0] SPFC_BOOT_START  = 13'h1c00;
    localparam int          SPFC_LK_GEN_LOW  = 0;
    localparam int          SPFC_LK_GEN_HIGH = 1;
    localparam int          SPFC_LK_APP_LOW  = 2;
    localparam int          SPFC_LK_APP_HIGH = 3;
    localparam int          SPFC_LK_BOOT_LOW = 4;
    localparam int          SPFC_LK_BOOT_HIGH = 5;

    typedef enum logic [2:0] {
        SPFC_IDLE  = 3'b001,
        SPFC_ARMED = 3'b010,
        SPFC_BUSY  = 3'b100
    } spfc_state_t;

    typedef struct packed {
        spfc_state_t st;
        logic        irq_en;
        logic        rww_busy;
        logic        reen;
        logic        lockset;
        logic        page_write_cmd;
        logic        page_erase_cmd;
        logic        store_program_enable;
        logic [2:0]  cnt;
        logic [5:0]  lock;
        logic        buf_loaded;
        logic        buf_we;
        logic [5:0]  buf_word;
        logic [15:0] buf_data;
        logic        buf_discard;
        logic        erase_start;
        logic        write_start;
        logic [6:0]  page;
        logic        halt;
        logic [7:0]  lpm_data;
        logic        lpm_valid;
        logic        lpm_denied;
        logic        spm_denied;
        logic        ack;
        logic [31:0] prdata;
        logic        slverr;
    } spfc_reg_t;
endpackage

//--- spfc_ctrl.sv
// Self-programming flash control: command register, arming window, section busy and lock protection
`timescale 1ns/10ps
module spfc_ctrl
    import spfc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire logic              ce_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              spm_in,
    input  wire logic              lpm_in,
    input  wire logic [15:0]       z_in,
    input  wire logic [7:0]        r0_in,
    input  wire logic [7:0]        r1_in,
    input  wire logic [7:0]        fuse_in,
    input  wire logic              exec_in_boot_in,
    input  wire logic              vectors_in_boot_in,
    input  wire logic              global_irq_in,
    input  wire logic              flash_done_in,
    input  wire logic              chip_erase_in,
    output logic                   buf_we_out,
    output logic      [5:0]        buf_word_out,
    output logic      [15:0]       buf_data_out,
    output logic                   buf_discard_out,
    output logic                   erase_start_out,
    output logic                   write_start_out,
    output logic      [6:0]        page_out,
    output logic                   cpu_halt_out,
    output logic                   rw_section_busy_out,
    output logic      [7:0]        lpm_data_out,
    output logic                   lpm_valid_out,
    output logic                   lpm_denied_out,
    output logic                   spm_denied_out,
    output logic                   prog_ready_irq_out,
    output logic                   ext_prog_refuse_out,
    output logic                   ext_verify_refuse_out,
    output logic                   fuse_locked_out,
    output logic                   boot_lock_locked_out,
    output logic                   boot_vec_irq_disable_out,
    output logic                   app_vec_irq_disable_out
);

    initial begin
        if (ADDR_W < 12 || ADDR_W > 32) begin
            $error("spfc_ctrl: ADDR_W must be 12 to 32");
        end
    end

    spfc_reg_t r;
    spfc_reg_t next_r;

    logic              acc;
    logic              wr_ok;
    logic              hit_csr;
    logic              hit_lock;
    logic [4:0]        cmd;
    logic              cmd_valid;
    logic [12:0]       tgt_word;
    logic              tgt_boot;
    logic              tgt_no_concurrent_read_section;
    logic              wr_blocked;
    logic              rd_blocked;
    logic [7:0]        csr_view;

    assign acc      = psel_in && penable_in;
    assign hit_csr  = paddr_in == ADDR_W'(SPFC_CSR_ADDR);
    assign hit_lock = paddr_in == ADDR_W'(SPFC_LOCK_ADDR);
    assign wr_ok    = acc && r.ack && pwrite_in && hit_csr;
    assign cmd      = pwdata_in[4:0];
    assign cmd_valid = cmd == SPFC_CMD_FILL || cmd == SPFC_CMD_ERASE || cmd == SPFC_CMD_WRITE ||
                       cmd == SPFC_CMD_LOCK || cmd == SPFC_CMD_REEN;

    assign tgt_word = z_in[13:1];
    assign tgt_no_concurrent_read_section = tgt_word >= SPFC_NO_CONCURRENT_READ_SECTION_BOUND;
    assign tgt_boot = tgt_word >= SPFC_BOOT_START;
    assign wr_blocked = tgt_boot ? !r.lock[SPFC_LK_BOOT_LOW] : !r.lock[SPFC_LK_APP_LOW];
    assign rd_blocked = (exec_in_boot_in ? (!tgt_boot && !r.lock[SPFC_LK_APP_HIGH])
                                         : (tgt_boot && !r.lock[SPFC_LK_BOOT_HIGH]))
                        || (!tgt_no_concurrent_read_section && r.rww_busy);

    assign csr_view = {r.irq_en, r.rww_busy, 1'b0, r.reen, r.lockset, r.page_write_cmd, r.page_erase_cmd, r.store_program_enable};

    always_comb begin
        next_r = r;
        next_r.buf_we      = 1'b0;
        next_r.buf_discard = 1'b0;
        next_r.erase_start = 1'b0;
        next_r.write_start = 1'b0;
        next_r.lpm_valid   = 1'b0;
        next_r.lpm_denied  = 1'b0;
        next_r.spm_denied  = 1'b0;

        // Bus slave: one wait state, data latched on the same edge as ready
        if (acc && !r.ack) begin
            next_r.ack    = 1'b1;
            next_r.slverr = !(hit_csr || hit_lock);
            if (hit_csr) begin
                next_r.prdata = {24'h000000, csr_view};
            end else if (hit_lock) begin
                next_r.prdata = {24'h000000, 2'b11, r.lock};
            end else begin
                next_r.prdata = 32'h00000000;
            end
        end else if (acc && r.ack) begin
            next_r.ack    = 1'b0;
            next_r.slverr = 1'b0;
        end

        // Command window and operations
        case (r.st)
            SPFC_IDLE: begin
            end
            SPFC_ARMED: begin
                if (spm_in) begin
                    next_r.store_program_enable   = 1'b0;
                    next_r.reen    = 1'b0;
                    next_r.lockset = 1'b0;
                    next_r.cnt     = 3'h0;
                    next_r.st      = SPFC_IDLE;
                    if (r.reen) begin
                        next_r.rww_busy = 1'b0;
                    end else if (r.lockset) begin
                        next_r.lock = r.lock & r0_in[5:0];
                    end else if (r.page_write_cmd || r.page_erase_cmd) begin
                        if (wr_blocked) begin
                            next_r.spm_denied = 1'b1;
                            next_r.page_write_cmd      = 1'b0;
                            next_r.page_erase_cmd      = 1'b0;
                        end else begin
                            next_r.store_program_enable       = 1'b1;
                            next_r.st          = SPFC_BUSY;
                            next_r.page        = z_in[13:7];
                            next_r.erase_start = r.page_erase_cmd;
                            next_r.write_start = r.page_write_cmd;
                            next_r.halt        = tgt_no_concurrent_read_section;
                            next_r.rww_busy    = r.rww_busy || !tgt_no_concurrent_read_section;
                            if (r.page_write_cmd) begin
                                next_r.buf_loaded = 1'b0;
                            end
                        end
                    end else begin
                        next_r.buf_we     = 1'b1;
                        next_r.buf_word   = z_in[6:1];
                        next_r.buf_data   = {r1_in, r0_in};
                        next_r.buf_loaded = 1'b1;
                        next_r.rww_busy   = 1'b0;
                    end
                end else if (r.cnt == 3'h1) begin
                    next_r.store_program_enable   = 1'b0;
                    next_r.reen    = 1'b0;
                    next_r.lockset = 1'b0;
                    next_r.page_write_cmd   = 1'b0;
                    next_r.page_erase_cmd   = 1'b0;
                    next_r.cnt     = 3'h0;
                    next_r.st      = SPFC_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 3'h1;
                end
                if (lpm_in && r.lockset && r.cnt > (SPFC_SPM_WINDOW - SPFC_LPM_WINDOW)) begin
                    next_r.lpm_valid = 1'b1;
                    next_r.lpm_data  = z_in[0] ? fuse_in : {2'b11, r.lock};
                end
            end
            SPFC_BUSY: begin
                if (flash_done_in) begin
                    next_r.store_program_enable = 1'b0;
                    next_r.page_write_cmd = 1'b0;
                    next_r.page_erase_cmd = 1'b0;
                    next_r.halt  = 1'b0;
                    next_r.st    = SPFC_IDLE;
                end
            end
            default: begin
                next_r.st = SPFC_IDLE;
            end
        endcase

        if (lpm_in && !(r.st == SPFC_ARMED && r.lockset) && rd_blocked) begin
            next_r.lpm_denied = 1'b1;
        end

        // Register write; a new valid pattern restarts the window unless an erase or write is busy
        if (wr_ok) begin
            next_r.irq_en = pwdata_in[SPFC_BIT_IRQ_EN];
            if (pwdata_in[SPFC_BIT_REEN] && r.buf_loaded) begin
                next_r.buf_discard = 1'b1;
                next_r.buf_loaded  = 1'b0;
            end
            if (r.st != SPFC_BUSY && cmd_valid) begin
                next_r.store_program_enable   = 1'b1;
                next_r.page_erase_cmd   = pwdata_in[SPFC_BIT_PAGE_ERASE_CMD];
                next_r.page_write_cmd   = pwdata_in[SPFC_BIT_PAGE_WRITE_CMD];
                next_r.lockset = pwdata_in[SPFC_BIT_LOCKSET];
                next_r.reen    = pwdata_in[SPFC_BIT_REEN];
                next_r.cnt     = SPFC_SPM_WINDOW;
                next_r.st      = SPFC_ARMED;
            end
        end

        if (chip_erase_in) begin
            next_r.lock = SPFC_LOCK_RESET;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r          <= '0;
            r.st       <= SPFC_IDLE;
            r.lock     <= SPFC_LOCK_RESET;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    assign prdata_out          = r.prdata;
    assign pready_out          = r.ack;
    assign pslverr_out         = r.ack && r.slverr;
    assign buf_we_out          = r.buf_we;
    assign buf_word_out        = r.buf_word;
    assign buf_data_out        = r.buf_data;
    assign buf_discard_out     = r.buf_discard;
    assign erase_start_out     = r.erase_start;
    assign write_start_out     = r.write_start;
    assign page_out            = r.page;
    assign cpu_halt_out        = r.halt;
    assign rw_section_busy_out = r.rww_busy;
    assign lpm_data_out        = r.lpm_data;
    assign lpm_valid_out       = r.lpm_valid;
    assign lpm_denied_out      = r.lpm_denied;
    assign spm_denied_out      = r.spm_denied;
    assign prog_ready_irq_out  = r.irq_en && global_irq_in && !r.store_program_enable;
    assign ext_prog_refuse_out   = !r.lock[SPFC_LK_GEN_LOW];
    assign fuse_locked_out       = !r.lock[SPFC_LK_GEN_LOW];
    assign ext_verify_refuse_out = !r.lock[SPFC_LK_GEN_LOW] && !r.lock[SPFC_LK_GEN_HIGH];
    assign boot_lock_locked_out  = !r.lock[SPFC_LK_GEN_LOW] && !r.lock[SPFC_LK_GEN_HIGH];
    assign boot_vec_irq_disable_out = !exec_in_boot_in && vectors_in_boot_in
                                      && !r.lock[SPFC_LK_APP_HIGH];
    assign app_vec_irq_disable_out  = exec_in_boot_in && !vectors_in_boot_in
                                      && !r.lock[SPFC_LK_BOOT_HIGH];

    AST_IRQ_LEVEL: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && wr_ok && r.st == SPFC_IDLE && !cmd_valid
        |=> prog_ready_irq_out == ($past(pwdata_in[SPFC_BIT_IRQ_EN]) && global_irq_in))
        else $error("ready interrupt does not follow its enables");

    AST_BUSY_SET: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && spm_in && (r.page_write_cmd || r.page_erase_cmd) && !wr_blocked && !tgt_no_concurrent_read_section
        && !wr_ok |=> rw_section_busy_out && r.st == SPFC_BUSY)
        else $error("section busy not set by erase or write");

    AST_BUSY_CLR_FILL: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && spm_in && r.store_program_enable && !r.page_write_cmd && !r.page_erase_cmd && !r.lockset && !r.reen
        |=> !rw_section_busy_out && buf_we_out)
        else $error("buffer load did not clear section busy");

    AST_RES_BIT: assert property (@(posedge clk_in) disable iff (!rstn_in)
        r.ack && hit_csr |-> prdata_out[5] == 1'b0)
        else $error("reserved bit reads as one");

    AST_DISCARD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && wr_ok && pwdata_in[SPFC_BIT_REEN] && r.buf_loaded |=> buf_discard_out && !r.buf_loaded)
        else $error("re-enable during load did not discard buffer");

    AST_LOCK_PROG: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && spm_in && r.lockset && !chip_erase_in
        |=> r.lock == ($past(r.lock) & $past(r0_in[5:0])))
        else $error("lock bits not programmed from register 0");

    AST_WINDOW_EXPIRE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && r.cnt == 3'h1 && !spm_in && !wr_ok
        |=> !r.store_program_enable && !r.lockset && !r.page_write_cmd && !r.page_erase_cmd && r.st == SPFC_IDLE)
        else $error("arming window did not close after four cycles");

    AST_STORE_PROGRAM_ENABLE_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        r.st == SPFC_BUSY && !flash_done_in |=> r.store_program_enable)
        else $error("store enable dropped during erase or write");

    AST_HALT: assert property (@(posedge clk_in) disable iff (!rstn_in)
        write_start_out |-> cpu_halt_out == (page_out >= SPFC_NO_CONCURRENT_READ_SECTION_BOUND[12:6]))
        else $error("halt does not match targeted section");

    AST_BAD_CMD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && wr_ok && !cmd_valid && r.st == SPFC_IDLE |=> r.st == SPFC_IDLE && !r.store_program_enable)
        else $error("invalid command pattern took effect");

    AST_LPM_LOCK: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && r.lockset && r.cnt >= 3'h2 && lpm_in && !z_in[0] && !spm_in
        |=> lpm_valid_out && lpm_data_out == {2'b11, $past(r.lock)})
        else $error("lock bits not returned to load");

    AST_VERIFY: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && spm_in && r.lockset && !chip_erase_in && r0_in[1:0] == 2'b00
        |=> ext_verify_refuse_out && ext_prog_refuse_out && fuse_locked_out && boot_lock_locked_out)
        else $error("general lock pair 0,0 did not refuse verify and lock boot bits");

    AST_REEN_CLR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && spm_in && r.reen && !wr_ok
        |=> !rw_section_busy_out && !r.reen && !r.store_program_enable)
        else $error("re-enable store did not unblock the section");

    AST_LOCKSET_CLR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && spm_in && r.lockset && !wr_ok |=> !r.lockset && !r.store_program_enable)
        else $error("lock-set bit not cleared after lock programming");

    AST_FILL_DATA: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && spm_in && !r.page_write_cmd && !r.page_erase_cmd && !r.lockset && !r.reen
        |=> buf_word_out == $past(z_in[6:1]) && buf_data_out == {$past(r1_in), $past(r0_in)})
        else $error("buffer word or data not taken from pointer and register pair");

    AST_PAGE_START: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && spm_in && (r.page_write_cmd || r.page_erase_cmd) && !wr_blocked && !wr_ok
        |=> (erase_start_out != write_start_out) && page_out == $past(z_in[13:7]))
        else $error("page operation not started on pointer page");

    AST_SPM_DENY: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_ARMED && spm_in && (r.page_write_cmd || r.page_erase_cmd) && wr_blocked
        |=> spm_denied_out && !erase_start_out && !write_start_out)
        else $error("protected section was erased or written");

    AST_BUSY_READ: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && lpm_in && r.rww_busy && !tgt_no_concurrent_read_section && !(r.st == SPFC_ARMED && r.lockset)
        |=> lpm_denied_out)
        else $error("load from busy section not blocked");

    AST_DONE_CLR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_BUSY && flash_done_in
        |=> !r.store_program_enable && !r.page_write_cmd && !r.page_erase_cmd && !cpu_halt_out && r.st == SPFC_IDLE)
        else $error("command bits or halt not cleared on completion");

    AST_FREEZE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !ce_in |=> $stable(r))
        else $error("state changed while clock enable low");

    AST_BUSY_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && r.st == SPFC_BUSY && !flash_done_in |=> r.st == SPFC_BUSY)
        else $error("erase or write left before completion");

    AST_IRQ_BUSY: assert property (@(posedge clk_in) disable iff (!rstn_in)
        r.st == SPFC_BUSY |-> !prog_ready_irq_out)
        else $error("ready interrupt raised during erase or write");

endmodule // spfc_ctrl

//--- spfc_core_model.sv
// Behavioural processor core: store and load program pulses, plus flash operation timing
`timescale 1ns/10ps
module spfc_core_model (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic op_start_in,
    output logic      spm_out,
    output logic      lpm_out,
    output logic      done_out
);
    int delay = 3;
    int cnt;

    initial begin
        spm_out = 1'b0;
        lpm_out = 1'b0;
    end

    // One instruction pulse, issued after gap edges
    task automatic pulse(input bit ld, input int gap);
        repeat (gap) @(posedge clk_in);
        if (ld) lpm_out <= 1'b1;
        else spm_out <= 1'b1;
        @(posedge clk_in);
        spm_out <= 1'b0;
        lpm_out <= 1'b0;
    endtask

    // Erase or write finishes a settable number of cycles after it starts
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt      <= 0;
            done_out <= 1'b0;
        end else begin
            done_out <= (cnt == 1);
            if (op_start_in) cnt <= delay;
            else if (cnt > 0) cnt <= cnt - 1;
        end
    end
endmodule // spfc_core_model

//--- self_program_flash_control_test.sv
// Self-checking testbench for the self-programming flash control block
`timescale 1ns/10ps
module self_program_flash_control_test;
    import spfc_pkg::*;
    logic clk_in = 0, rstn_in = 0, ce_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, prdata_out;
    logic [15:0] z_in = '0, buf_data_out;
    logic [7:0] r0_in = '0, r1_in = '0, fuse_in = '0, lpm_data_out, v;
    logic exec_in_boot_in = 0, vectors_in_boot_in = 0, global_irq_in = 0, chip_erase_in = 0;
    logic pready_out, pslverr_out, spm_in, lpm_in, flash_done_in, buf_we_out, buf_discard_out;
    logic erase_start_out, write_start_out, cpu_halt_out, rw_section_busy_out, lpm_valid_out;
    logic lpm_denied_out, spm_denied_out, prog_ready_irq_out, ext_prog_refuse_out, ext_verify_refuse_out;
    logic fuse_locked_out, boot_lock_locked_out, boot_vec_irq_disable_out, app_vec_irq_disable_out;
    logic [5:0] buf_word_out;
    logic [6:0] page_out;
    logic [32:0] rd_q[$];
    logic [21:0] bw_q[$];
    logic [7:0] pg_q[$], lp_q[$];
    logic [4:0] bad[6] = '{5'h07, 5'h19, 5'h0b, 5'h02, 5'h10, 5'h1f};
    int fails = 0, total_checks = 0, cyc = 0, n_disc = 0, n_sden = 0, n_lden = 0;

    spfc_ctrl spfc_ctrl_inst (.*);
    spfc_core_model spfc_core_model_inst (.clk_in(clk_in), .rstn_in(rstn_in),
        .op_start_in(erase_start_out | write_start_out), .spm_out(spm_in), .lpm_out(lpm_in),
        .done_out(flash_done_in));

    always #50 clk_in = ~clk_in;

    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic final_report;
        if (fails == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1) @(posedge clk_in);
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wr(input logic [7:0] d);
        apb(1'b1, SPFC_CSR_ADDR, {24'h0, d});
    endtask

    // Erase or write one page, check busy and halt, then let the flash finish
    task automatic flash_op(input logic [4:0] cmd, input logic [6:0] p);
        z_in <= {2'b0, p, 7'h0};
        wr({3'b0, cmd});
        pg_q.push_back({cmd == SPFC_CMD_WRITE, p});
        spfc_core_model_inst.pulse(1'b0, 0);
        repeat (2) @(posedge clk_in);
        chk("halt", p >= 7'h70, cpu_halt_out);
        chk("busy", p < 7'h70, rw_section_busy_out);
        rd(SPFC_CSR_ADDR, {26'h0, p < 7'h70, 6'h0} | cmd);
        repeat (spfc_core_model_inst.delay + 2) @(posedge clk_in);
        rd(SPFC_CSR_ADDR, {26'h0, p < 7'h70, 6'h0});
    endtask

    always @(posedge clk_in) begin
        cyc++;
        if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1)
            chk("read", rd_q.size() ? rd_q.pop_front() : 'x, {pslverr_out, prdata_out});
        if (buf_we_out === 1'b1)
            chk("fill", bw_q.size() ? bw_q.pop_front() : 'x, {buf_word_out, buf_data_out});
        if ((erase_start_out | write_start_out) === 1'b1)
            chk("page", pg_q.size() ? pg_q.pop_front() : 'x, {write_start_out, page_out});
        if (lpm_valid_out === 1'b1)
            chk("lpm", lp_q.size() ? lp_q.pop_front() : 'x, lpm_data_out);
        n_disc += buf_discard_out;
        n_sden += spm_denied_out;
        n_lden += lpm_denied_out;
        if (cyc == 30000) begin
            fails++;
            final_report;
        end
    end

    initial begin
        void'($urandom(32'h14a08576));
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd(SPFC_CSR_ADDR, {25'h0, SPFC_CSR_RESET});
        rd(SPFC_LOCK_ADDR, 33'hff);
        rd(12'h100, 33'h100000000);
        apb(1'b1, 12'h100, 32'hff);
        wr(8'he0);
        rd(SPFC_CSR_ADDR, 33'h80);
        global_irq_in <= 1'b1;
        @(posedge clk_in);
        chk("irq", 1, prog_ready_irq_out);
        wr(8'h81);
        @(posedge clk_in);
        chk("irq", 0, prog_ready_irq_out);
        repeat (5) @(posedge clk_in);
        chk("irq", 1, prog_ready_irq_out);
        rd(SPFC_CSR_ADDR, 33'h80);
        global_irq_in <= 1'b0;
        wr(8'h00);
        chk("irq", 0, prog_ready_irq_out);
        z_in  <= 16'($urandom);
        r0_in <= 8'($urandom);
        r1_in <= 8'($urandom);
        wr({3'b0, SPFC_CMD_FILL});
        bw_q.push_back({z_in[6:1], r1_in, r0_in});
        spfc_core_model_inst.pulse(1'b0, 3);
        rd(SPFC_CSR_ADDR, 33'h0);
        wr({3'b0, SPFC_CMD_REEN});
        repeat (3) @(posedge clk_in);
        chk("discard", 1, n_disc);
        foreach (bad[i]) begin
            v = {1'($urandom), 2'b0, bad[i]};
            wr(v);
            spfc_core_model_inst.pulse(1'b0, 0);
            rd(SPFC_CSR_ADDR, {25'h0, v[7], 7'h0});
        end
        wr(8'h01);
        ce_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        ce_in <= 1'b1;
        rd(SPFC_CSR_ADDR, 33'h01);
        wr(8'h00);
        spfc_core_model_inst.delay = 20;
        flash_op(SPFC_CMD_ERASE, 7'($urandom_range(0, 111)));
        wr({3'b0, SPFC_CMD_REEN});
        spfc_core_model_inst.pulse(1'b0, 1);
        rd(SPFC_CSR_ADDR, 33'h0);
        flash_op(SPFC_CMD_WRITE, 7'($urandom_range(112, 127)));
        flash_op(SPFC_CMD_WRITE, 7'($urandom_range(0, 111)));
        spfc_core_model_inst.pulse(1'b1, 0);
        wr({3'b0, SPFC_CMD_FILL});
        bw_q.push_back({z_in[6:1], r1_in, r0_in});
        spfc_core_model_inst.pulse(1'b0, 0);
        rd(SPFC_CSR_ADDR, 33'h0);
        fuse_in <= 8'($urandom);
        wr({3'b0, SPFC_CMD_LOCK});
        lp_q.push_back(8'hff);
        spfc_core_model_inst.pulse(1'b1, 0);
        z_in <= 16'h1;
        wr({3'b0, SPFC_CMD_LOCK});
        lp_q.push_back(fuse_in);
        spfc_core_model_inst.pulse(1'b1, 2);
        repeat (5) @(posedge clk_in);
        rd(SPFC_CSR_ADDR, 33'h0);
        // Section protection first, general pair last
        r0_in <= 8'h03;
        wr({3'b0, SPFC_CMD_LOCK});
        spfc_core_model_inst.pulse(1'b0, 0);
        rd(SPFC_LOCK_ADDR, 33'hc3);
        vectors_in_boot_in <= 1'b1;
        @(posedge clk_in);
        chk("vec", 2'b10, {boot_vec_irq_disable_out, app_vec_irq_disable_out});
        exec_in_boot_in    <= 1'b1;
        vectors_in_boot_in <= 1'b0;
        z_in               <= 16'h0;
        wr({3'b0, SPFC_CMD_ERASE});
        chk("vec", 2'b01, {boot_vec_irq_disable_out, app_vec_irq_disable_out});
        spfc_core_model_inst.pulse(1'b0, 0);
        repeat (3) @(posedge clk_in);
        chk("deny", 1, n_sden);
        chk("refuse", 4'h0, {ext_prog_refuse_out, fuse_locked_out, ext_verify_refuse_out});
        spfc_core_model_inst.pulse(1'b1, 0);
        repeat (2) @(posedge clk_in);
        chk("ldeny", 2, n_lden);
        r0_in <= 8'hfe;
        wr({3'b0, SPFC_CMD_LOCK});
        spfc_core_model_inst.pulse(1'b0, 0);
        repeat (2) @(posedge clk_in);
        chk("refuse", 4'hc, {ext_prog_refuse_out, fuse_locked_out, ext_verify_refuse_out,
            boot_lock_locked_out});
        r0_in <= 8'hfc;
        wr({3'b0, SPFC_CMD_LOCK});
        spfc_core_model_inst.pulse(1'b0, 0);
        repeat (2) @(posedge clk_in);
        chk("refuse", 4'hf, {ext_prog_refuse_out, fuse_locked_out, ext_verify_refuse_out,
            boot_lock_locked_out});
        rd(SPFC_LOCK_ADDR, 33'hc0);
        chip_erase_in <= 1'b1;
        @(posedge clk_in);
        chip_erase_in <= 1'b0;
        rd(SPFC_LOCK_ADDR, 33'hff);
        final_report;
    end
endmodule // self_program_flash_control_test
